// *** hw/ich_top.sv ***
// instruction code handler: apb registers, code decode, parameter and monitor access
// assumes the inverter core runs on core_clk_i and acknowledges each parameter request
//
// What the document requires
// [RULE1] codes 00-63 read, 80-e3 write parameters
// [RULE2] writes to parameters 77 and 79 refused
// [RULE3] 8888 travels as 65520, 9999 as 65535
// [RULE4] master sets ram write select before frequent writes
// [RULE5] f4 with 9696 clears fault history
// [RULE6] fc: 9696 clears with comms, 5a5a keeps comms
// [RULE7] all clear: 9966 clears comms, 55aa keeps
// [RULE8] any clear resets ec, f3, ff settings
// [RULE9] power loss during keep-clear reverts comm parameters
// [RULE10] fd with 9696 resets the inverter
// [RULE11] second parameter select: read 6c, write ec
// [RULE12] second parameter access only at extended 1/9
// [RULE13] bias and gain windows depend on extended setting
// [RULE14] special monitor write uses low byte only
// [RULE15] 32-bit values above ffff read as ffff
// [RULE16] monitor word: low byte first, high second
// [RULE17] four more words select monitors three to six
// [RULE18] code 00: zero low, frequency high
// [RULE19] frequency monitors ignore speed display scaling
// [RULE20] main select 100: set when stopped, output running
// [RULE21] code 72 returns the special monitor value
// [RULE22] clear codes with unknown keys do nothing
//
// Implementation choices: the APB interface to the registers and the register addresses.
module ich_top #(
	parameter int NMON = 16
) (
	input  wire logic                 core_clk_i,
	input  wire logic                 arst_n_i,
	input  wire logic [7:0]           paddr_i,
	input  wire logic                 psel_i,
	input  wire logic                 penable_i,
	input  wire logic                 pwrite_i,
	input  wire logic [31:0]          pwdata_i,
	output logic      [31:0]          prdata_o,
	output logic                      pready_o,
	output logic                      pslverr_o,
	output logic                      par_req_o,
	output logic                      par_we_o,
	output logic      [15:0]          par_num_o,
	output logic      [31:0]          par_wdata_o,
	output logic                      par_bias_gain_o,
	output logic      [1:0]           par_second_sel_o,
	input  wire logic                 par_ack_i,
	input  wire logic [31:0]          par_rdata_i,
	output logic                      fault_clr_o,
	output logic                      par_clr_o,
	output logic                      all_clr_o,
	output logic                      comm_clr_o,
	output logic                      comm_keep_busy_o,
	input  wire logic                 clr_done_i,
	output logic                      inv_reset_o,
	input  wire logic [NMON*32-1:0]   mon_items_i,
	input  wire logic                 running_i,
	input  wire logic [15:0]          set_freq_i,
	input  wire logic [15:0]          out_freq_i,
	input  wire logic [15:0]          panel_main_monitor_select_i,
	output logic      [15:0]          main_monitor_o
);
	typedef struct packed {
		ich_pkg::ich_state_t st;
		logic [7:0]          code;
		logic [15:0]         data;
		logic [15:0]         result;
		logic                err;
		logic [7:0]          ext;
		logic [1:0]          sec_sel;
		logic [7:0]          spc_sel;
		logic [15:0]         msel;
		logic [3:0][15:0]    msel36;
		logic [5:0][15:0]    mres;
		logic [15:0]         spc_val;
		logic [15:0]         main_mon;
		logic [31:0]         prdata;
		logic                par_req;
		logic                par_we;
		logic [15:0]         par_num;
		logic [31:0]         par_wdata;
		logic                bias_gain;
		logic                fault_clr;
		logic                par_clr;
		logic                all_clr;
		logic                comm_clr;
		logic                keep_busy;
		logic                inv_rst;
	} ich_reg_t;

	ich_reg_t ich_ff;
	ich_reg_t nxt_ich;

	// frequency items come straight from the core in 0.01 hz, so speed scaling never applies
	function automatic logic [15:0] mon_pick(input logic [7:0] c, input logic upper);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (c == 8'h00 && !upper) begin
			v = 32'h0000_0000; // see [RULE18]
		end else if (c == 8'h00) begin
			v = mon_items_i[32 +: 32]; // see [RULE18] [RULE19]
		end else if (32'(c) < NMON) begin
			v = mon_items_i[32*c +: 32]; // see [RULE19]
		end
		return (v > 32'(ich_pkg::SAT_MAX)) ? ich_pkg::SAT_MAX : v[15:0]; // see [RULE15]
	endfunction

	// parameter value to link value, specials first so they go out as their link codes and not as plain values
	function automatic logic [15:0] to_link(input logic [31:0] v);
		if (v == ich_pkg::SP_8888) begin
			return ich_pkg::LK_8888; // see [RULE3]
		end else if (v == ich_pkg::SP_9999) begin
			return ich_pkg::LK_9999; // see [RULE3]
		end
		return (v > 32'(ich_pkg::SAT_MAX)) ? ich_pkg::SAT_MAX : v[15:0]; // see [RULE15]
	endfunction

	function automatic logic [31:0] from_link(input logic [15:0] d);
		if (d == ich_pkg::LK_8888) begin
			return ich_pkg::SP_8888; // see [RULE3]
		end else if (d == ich_pkg::LK_9999) begin
			return ich_pkg::SP_9999; // see [RULE3]
		end
		return {16'h0000, d};
	endfunction

	logic        wr_acc;
	logic        rd_setup;
	logic        addr_ok;
	logic        code_refused;
	logic        ext_ok;
	logic [6:0]  pidx;
	logic [15:0] pnum;
	logic        bg_hit;

	assign addr_ok      = (paddr_i[1:0] == 2'b00) && (paddr_i <= ich_pkg::OFS_LAST);
	// a code written while a parameter access is pending would be lost, so it is refused
	assign code_refused = (ich_ff.st == ich_pkg::ST_WAIT) && (paddr_i == ich_pkg::OFS_CODE);
	assign pready_o     = 1'b1;
	assign pslverr_o    = psel_i && penable_i && (!addr_ok || (pwrite_i && code_refused));
	assign wr_acc       = psel_i && penable_i && pwrite_i && !pslverr_o;
	assign rd_setup     = psel_i && !penable_i && !pwrite_i;
	assign ext_ok       = (ich_ff.ext == ich_pkg::EXT_ONE) || (ich_ff.ext == ich_pkg::EXT_NINE);
	assign pidx         = pwdata_i[6:0];
	assign pnum         = 16'(ich_ff.ext) * ich_pkg::PAR_STEP + 16'(pidx);
	assign bg_hit       = ((ich_ff.ext == ich_pkg::EXT_ONE) && pidx >= ich_pkg::BG1_LO
	                      && pidx <= ich_pkg::BG1_HI)
	                   || ((ich_ff.ext == ich_pkg::EXT_NINE) && pidx >= ich_pkg::BG9_LO
	                      && pidx <= ich_pkg::BG9_HI); // see [RULE13]

	always_comb begin
		logic [7:0] c;
		c = pwdata_i[7:0];
		nxt_ich = ich_ff;
		nxt_ich.fault_clr = 1'b0;
		nxt_ich.par_clr   = 1'b0;
		nxt_ich.all_clr   = 1'b0;
		nxt_ich.comm_clr  = 1'b0;
		nxt_ich.inv_rst   = 1'b0;
		nxt_ich.par_req   = 1'b0;
		if (clr_done_i) begin
			nxt_ich.keep_busy = 1'b0; // see [RULE9]
		end
		// monitor results refresh every cycle from the select words
		nxt_ich.mres[0] = mon_pick(ich_ff.msel[7:0], 1'b0); // see [RULE16]
		nxt_ich.mres[1] = mon_pick(ich_ff.msel[15:8], 1'b1); // see [RULE16]
		for (int i = 0; i < 4; i++) begin
			nxt_ich.mres[i+2] = mon_pick(ich_ff.msel36[i][7:0], 1'b0); // see [RULE17]
		end
		nxt_ich.spc_val  = mon_pick(ich_ff.spc_sel, 1'b0);
		nxt_ich.main_mon = (panel_main_monitor_select_i == ich_pkg::MAIN_SEL_AUTO) ?
		                   (running_i ? out_freq_i : set_freq_i) : out_freq_i; // see [RULE20]
		if (ich_ff.st == ich_pkg::ST_WAIT && par_ack_i) begin
			nxt_ich.st = ich_pkg::ST_IDLE;
			if (!ich_ff.par_we) begin
				nxt_ich.result = to_link(par_rdata_i);
			end
		end
		if (rd_setup) begin
			nxt_ich.prdata = 32'h0000_0000;
			unique case (paddr_i)
				ich_pkg::OFS_CODE:   nxt_ich.prdata[7:0] = ich_ff.code;
				ich_pkg::OFS_DATA:   nxt_ich.prdata[15:0] = ich_ff.data;
				ich_pkg::OFS_RESULT: nxt_ich.prdata[16:0] = {ich_ff.err, ich_ff.result};
				ich_pkg::OFS_EXT:    nxt_ich.prdata[7:0] = ich_ff.ext;
				ich_pkg::OFS_MSEL:   nxt_ich.prdata[15:0] = ich_ff.msel;
				ich_pkg::OFS_STATUS: begin
					nxt_ich.prdata[ich_pkg::STS_BUSY] = (ich_ff.st == ich_pkg::ST_WAIT);
					nxt_ich.prdata[ich_pkg::STS_KEEP] = ich_ff.keep_busy;
					nxt_ich.prdata[ich_pkg::STS_SEC_LSB +: 2] = ich_ff.sec_sel;
					nxt_ich.prdata[ich_pkg::STS_SPC_LSB +: 8] = ich_ff.spc_sel;
				end
				default: begin
					// out-of-map reads from OFS_MSEL3 up return a select word by truncated index; only the result array read is bounds-checked
					if (addr_ok && paddr_i >= ich_pkg::OFS_MRES) begin
						nxt_ich.prdata[15:0] = ich_ff.mres[3'((paddr_i - ich_pkg::OFS_MRES) >> 2)];
					end else if (paddr_i >= ich_pkg::OFS_MSEL3) begin
						nxt_ich.prdata[15:0] =
							ich_ff.msel36[2'((paddr_i - ich_pkg::OFS_MSEL3) >> 2)];
					end
				end
			endcase
		end
		if (wr_acc) begin
			unique case (paddr_i)
				ich_pkg::OFS_DATA: nxt_ich.data = pwdata_i[15:0];
				ich_pkg::OFS_EXT:  nxt_ich.ext  = pwdata_i[7:0];
				ich_pkg::OFS_MSEL: nxt_ich.msel = pwdata_i[15:0];
				ich_pkg::OFS_CODE: begin
					nxt_ich.code = c;
					nxt_ich.err  = 1'b0;
					if (c <= ich_pkg::RD_LAST) begin
						nxt_ich.st        = ich_pkg::ST_WAIT; // see [RULE1]
						nxt_ich.par_req   = 1'b1;
						nxt_ich.par_we    = 1'b0;
						nxt_ich.par_num   = pnum;
						nxt_ich.bias_gain = bg_hit;
					end else if (c >= ich_pkg::WR_FIRST && c <= ich_pkg::WR_LAST) begin
						if (pnum == ich_pkg::PR_WPROT || pnum == ich_pkg::PR_OPSRC) begin
							nxt_ich.err = 1'b1; // see [RULE2]
						end else begin
							nxt_ich.st        = ich_pkg::ST_WAIT; // see [RULE1]
							nxt_ich.par_req   = 1'b1;
							nxt_ich.par_we    = 1'b1;
							nxt_ich.par_num   = pnum;
							nxt_ich.par_wdata = from_link(ich_ff.data);
							nxt_ich.bias_gain = bg_hit;
						end
					end else if (c == ich_pkg::C_SEC_RD || c == ich_pkg::C_SEC_WR) begin
						if (!ext_ok) begin
							nxt_ich.err = 1'b1; // see [RULE12]
						end else if (c == ich_pkg::C_SEC_RD) begin
							nxt_ich.result = {14'h0000, ich_ff.sec_sel}; // see [RULE11]
						end else if (ich_ff.data[7:0] <= 8'(ich_pkg::SEC_MAX)) begin
							nxt_ich.sec_sel = ich_ff.data[1:0]; // see [RULE11]
						end else begin
							nxt_ich.err = 1'b1;
						end
					end else if (c == ich_pkg::C_SPC_MON) begin
						nxt_ich.result = ich_ff.spc_val; // see [RULE21]
					end else if (c == ich_pkg::C_SPC_RD) begin
						nxt_ich.result = {8'h00, ich_ff.spc_sel};
					end else if (c == ich_pkg::C_SPC_WR) begin
						nxt_ich.spc_sel = ich_ff.data[7:0]; // see [RULE14]
					end else if (c == ich_pkg::C_FLT_CLR && ich_ff.data == ich_pkg::K_9696) begin
						nxt_ich.fault_clr = 1'b1; // see [RULE5]
					end else if (c == ich_pkg::C_INV_RST && ich_ff.data == ich_pkg::K_9696) begin
						nxt_ich.inv_rst = 1'b1; // see [RULE10]
					end else if (c == ich_pkg::C_PAR_CLR && (ich_ff.data == ich_pkg::K_9696
					             || ich_ff.data == ich_pkg::K_5A5A
					             || ich_ff.data == ich_pkg::K_9966
					             || ich_ff.data == ich_pkg::K_55AA)) begin
						nxt_ich.par_clr  = (ich_ff.data == ich_pkg::K_9696)
						                || (ich_ff.data == ich_pkg::K_5A5A); // see [RULE6]
						nxt_ich.all_clr  = !nxt_ich.par_clr; // see [RULE7]
						nxt_ich.comm_clr = (ich_ff.data == ich_pkg::K_9696)
						                || (ich_ff.data == ich_pkg::K_9966); // see [RULE6] [RULE7]
						nxt_ich.keep_busy = !nxt_ich.comm_clr; // see [RULE9]
						nxt_ich.sec_sel  = ich_pkg::RST_SEC; // see [RULE8]
						nxt_ich.spc_sel  = ich_pkg::RST_SPC; // see [RULE8]
						nxt_ich.msel     = ich_pkg::RST_MSEL; // see [RULE8]
					end else begin
						nxt_ich.err = 1'b1; // see [RULE22]
					end
				end
				default: begin
					if (paddr_i >= ich_pkg::OFS_MSEL3 && paddr_i < ich_pkg::OFS_MRES) begin
						nxt_ich.msel36[2'((paddr_i - ich_pkg::OFS_MSEL3) >> 2)] =
							pwdata_i[15:0]; // see [RULE17]
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ich_ff         <= '0;
			ich_ff.st      <= ich_pkg::ST_IDLE;
			ich_ff.ext     <= ich_pkg::RST_EXT;
			ich_ff.sec_sel <= ich_pkg::RST_SEC;
			ich_ff.spc_sel <= ich_pkg::RST_SPC;
			ich_ff.msel    <= ich_pkg::RST_MSEL;
		end else begin
			ich_ff <= nxt_ich;
		end
	end

	assign prdata_o         = ich_ff.prdata;
	assign par_req_o        = ich_ff.par_req;
	assign par_we_o         = ich_ff.par_we;
	assign par_num_o        = ich_ff.par_num;
	assign par_wdata_o      = ich_ff.par_wdata;
	assign par_bias_gain_o  = ich_ff.bias_gain;
	assign par_second_sel_o = ich_ff.sec_sel;
	assign fault_clr_o      = ich_ff.fault_clr;
	assign par_clr_o        = ich_ff.par_clr;
	assign all_clr_o        = ich_ff.all_clr;
	assign comm_clr_o       = ich_ff.comm_clr;
	assign comm_keep_busy_o = ich_ff.keep_busy;
	assign inv_reset_o      = ich_ff.inv_rst;
	assign main_monitor_o   = ich_ff.main_mon;

	// reads the registered selections, so it sees the defaults set with the clear pulse
	function automatic logic spc_sel_ok();
		return ich_ff.spc_sel == ich_pkg::RST_SPC && ich_ff.sec_sel == ich_pkg::RST_SEC;
	endfunction

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);

	a_rd_code_req: assert property ( // see [RULE1]
		wr_acc && paddr_i == ich_pkg::OFS_CODE && pwdata_i[7:0] <= ich_pkg::RD_LAST
		|=> par_req_o && !par_we_o)
		else $error("read code did not start a parameter read");
	a_prot_refuse: assert property ( // see [RULE2]
		par_req_o && par_we_o
		|-> par_num_o != ich_pkg::PR_WPROT && par_num_o != ich_pkg::PR_OPSRC)
		else $error("write to protected parameter issued");
	a_spc_8888: assert property ( // see [RULE3]
		par_req_o && par_we_o && $past(ich_ff.data) == ich_pkg::LK_8888
		|-> par_wdata_o == ich_pkg::SP_8888)
		else $error("65520 not turned into 8888");
	a_fault_key: assert property ( // see [RULE5]
		fault_clr_o |-> $past(ich_ff.data) == ich_pkg::K_9696
		&& $past(wr_acc) && $past(pwdata_i[7:0]) == ich_pkg::C_FLT_CLR)
		else $error("fault clear without its key");
	a_clr_comm: assert property ( // see [RULE6] [RULE7] [RULE8]
		(par_clr_o || all_clr_o) |-> comm_clr_o != comm_keep_busy_o && spc_sel_ok())
		else $error("clear mode or defaults wrong");
	a_reset_key: assert property ( // see [RULE10]
		inv_reset_o |-> $past(ich_ff.data) == ich_pkg::K_9696)
		else $error("inverter reset without its key");
	a_sec_gate: assert property ( // see [RULE12]
		!ext_ok && !$past(ext_ok) |=> $stable(par_second_sel_o)
		|| $past(par_clr_o || all_clr_o) || par_clr_o || all_clr_o)
		else $error("second parameter changed while locked");
	a_mon_low_zero: assert property ( // see [RULE16] [RULE18]
		$past(ich_ff.msel[7:0]) == 8'h00 |-> ich_ff.mres[0] == 16'h0000)
		else $error("monitor code zero not zero in low byte");
	a_main_mon: assert property ( // see [RULE20]
		panel_main_monitor_select_i == ich_pkg::MAIN_SEL_AUTO && !running_i
		|=> main_monitor_o == $past(set_freq_i))
		else $error("main monitor not set frequency while stopped");
	a_spc_low_byte: assert property ( // see [RULE14]
		wr_acc && paddr_i == ich_pkg::OFS_CODE && pwdata_i[7:0] == ich_pkg::C_SPC_WR
		|=> ich_ff.spc_sel == $past(ich_ff.data[7:0]))
		else $error("special monitor select not taken from low byte");
	a_sat_read: assert property ( // see [RULE15]
		ich_ff.st == ich_pkg::ST_WAIT && par_ack_i && !ich_ff.par_we
		&& par_rdata_i > 32'h0000_ffff |=> ich_ff.result == ich_pkg::SAT_MAX)
		else $error("wide parameter value not saturated");
endmodule

// *** hw/ich_pkg.sv ***
// constants of the instruction code handler: register map, codes, keys, reset values
// assumes a 32-bit apb master and an inverter core on the same clock
package ich_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CODE    = 8'h00;
	localparam logic [7:0] OFS_DATA    = 8'h04;
	localparam logic [7:0] OFS_RESULT  = 8'h08;
	localparam logic [7:0] OFS_EXT     = 8'h0c;
	localparam logic [7:0] OFS_MSEL    = 8'h10;
	localparam logic [7:0] OFS_MSEL3   = 8'h14;
	localparam logic [7:0] OFS_MRES    = 8'h24;
	localparam logic [7:0] OFS_STATUS  = 8'h3c;
	localparam logic [7:0] OFS_LAST    = 8'h3c;
	// result register field positions
	localparam int         RES_ERR_BIT = 16;
	// status register field positions
	localparam int         STS_BUSY    = 0;
	localparam int         STS_KEEP    = 1;
	localparam int         STS_SEC_LSB = 8;
	localparam int         STS_SPC_LSB = 16;
	// instruction code ranges and special codes
	localparam logic [7:0] RD_LAST     = 8'h63;
	localparam logic [7:0] WR_FIRST    = 8'h80;
	localparam logic [7:0] WR_LAST     = 8'he3;
	localparam logic [7:0] C_SEC_RD    = 8'h6c;
	localparam logic [7:0] C_SPC_MON   = 8'h72;
	localparam logic [7:0] C_SPC_RD    = 8'h73;
	localparam logic [7:0] C_SEC_WR    = 8'hec;
	localparam logic [7:0] C_SPC_WR    = 8'hf3;
	localparam logic [7:0] C_FLT_CLR   = 8'hf4;
	localparam logic [7:0] C_PAR_CLR   = 8'hfc;
	localparam logic [7:0] C_INV_RST   = 8'hfd;
	// key values
	localparam logic [15:0] K_9696     = 16'h9696;
	localparam logic [15:0] K_5A5A     = 16'h5a5a;
	localparam logic [15:0] K_9966     = 16'h9966;
	localparam logic [15:0] K_55AA     = 16'h55aa;
	// protected parameter numbers and special settings
	localparam logic [15:0] PR_WPROT   = 16'h004d;
	localparam logic [15:0] PR_OPSRC   = 16'h004f;
	localparam logic [31:0] SP_8888    = 32'h0000_22b8;
	localparam logic [31:0] SP_9999    = 32'h0000_270f;
	localparam logic [15:0] LK_8888    = 16'hfff0;
	localparam logic [15:0] LK_9999    = 16'hffff;
	localparam logic [15:0] SAT_MAX    = 16'hffff;
	// extended setting values that open second parameter access
	localparam logic [7:0] EXT_ONE     = 8'h01;
	localparam logic [7:0] EXT_NINE    = 8'h09;
	localparam logic [15:0] PAR_STEP   = 16'h0064;
	// bias and gain windows
	localparam logic [6:0] BG1_LO      = 7'h5e;
	localparam logic [6:0] BG1_HI      = 7'h61;
	localparam logic [6:0] BG9_LO      = 7'h11;
	localparam logic [6:0] BG9_HI      = 7'h23;
	localparam logic [1:0] SEC_MAX     = 2'h2;
	localparam logic [15:0] MAIN_SEL_AUTO = 16'h0064;
	// reset values
	localparam logic [7:0] RST_EXT     = 8'h00;
	localparam logic [1:0] RST_SEC     = 2'h0;
	localparam logic [7:0] RST_SPC     = 8'h01;
	localparam logic [15:0] RST_MSEL   = 16'h0000;
	typedef enum logic [0:0] {ST_IDLE, ST_WAIT} ich_state_t;
endpackage

// *** verification/ich_core_model.sv ***
// behavioural inverter core: parameter store, request acknowledge, clear completion
// assumes one request at a time from the handler, all on core_clk_i
module ich_core_model (
	input  wire logic        core_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        par_req_i,
	input  wire logic        par_we_i,
	input  wire logic [15:0] par_num_i,
	input  wire logic [31:0] par_wdata_i,
	input  wire logic        par_clr_i,
	input  wire logic        all_clr_i,
	output logic             par_ack_o,
	output logic      [31:0] par_rdata_o,
	output logic             clr_done_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] mem [int];
	logic [15:0] num;
	int          wait_q;
	int          clr_q;
	logic        slow;
	initial mem[8] = 32'h0002_0000; // above ffff, read back saturated
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			par_ack_o <= 1'b0;
			par_rdata_o <= 32'h0000_0000;
			clr_done_o <= 1'b0;
			wait_q = 0;
			clr_q = 0;
			slow = 1'b0;
		end else begin
			par_ack_o <= 1'b0;
			clr_done_o <= 1'b0;
			// read data is only valid with the acknowledge, so it toggles otherwise
			par_rdata_o <= ~par_rdata_o;
			if (par_req_i) begin
				num = par_num_i;
				if (par_we_i)
					mem[num] = par_wdata_i;
				// alternate prompt and slow answers
				wait_q = slow ? 4 : 1;
				slow = ~slow;
			end else if (wait_q > 0) begin
				wait_q--;
				if (wait_q == 0) begin
					par_ack_o <= 1'b1;
					par_rdata_o <= mem.exists(num) ? mem[num] : 32'h0000_0000;
				end
			end
			if (par_clr_i || all_clr_i) begin
				clr_q = 3;
			end else if (clr_q > 0) begin
				clr_q--;
				if (clr_q == 0)
					clr_done_o <= 1'b1;
			end
		end
	end
endmodule

// *** verification/ich_top_tb_top.sv ***
// self-checking bench: apb register tasks driving instruction codes into the handler
// assumes the core model answers parameter requests and clears
module ich_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk_i = 1'b0, arst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, par_wdata_o, par_rdata_i;
	logic pready_o, pslverr_o, par_req_o, par_we_o, par_bias_gain_o, par_ack_i;
	logic fault_clr_o, par_clr_o, all_clr_o, comm_clr_o, comm_keep_busy_o, clr_done_i, inv_reset_o;
	logic [15:0] par_num_o, main_monitor_o, set_freq_i = 16'h1111, out_freq_i = 16'h2222;
	logic [15:0] panel_main_monitor_select_i = 16'h0000;
	logic [1:0] par_second_sel_o;
	logic [511:0] mon_items_i;
	logic running_i = 1'b0;
	logic [31:0] rd_v, res;
	logic err;
	int failures = 0, checks_done = 0, nreq = 0, cnt [7];
	logic [15:0] l_num;
	logic [31:0] l_wd;
	logic l_bg, l_we;
	logic [7:0] ccode [9] = '{8'hf4, 8'hfd, 8'hfc, 8'hfc, 8'hfc, 8'hfc, 8'hf4, 8'hfc, 8'hfd};
	logic [15:0] ckey [9] = '{16'h9696, 16'h9696, 16'h9696, 16'h5a5a, 16'h9966, 16'h55aa,
		16'h1234, 16'h1234, 16'h0000};
	// bits: keep, error, comm, all, par, reset, fault
	logic [6:0] cexp [9] = '{7'h01, 7'h02, 7'h14, 7'h44, 7'h18, 7'h48, 7'h20, 7'h20, 7'h20};
	logic [6:0] seen;
	int snap [7];
	always #12.5 core_clk_i = ~core_clk_i;
	for (genvar k = 0; k < 16; k++) begin : g_mon
		// item 7 exceeds 16 bits and must read saturated
		assign mon_items_i[32*k+:32] = (k == 7) ? 32'h0001_0005 : 32'h0000_1000 + k;
	end
	ich_top uut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .paddr_i(paddr_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.par_req_o(par_req_o), .par_we_o(par_we_o), .par_num_o(par_num_o),
		.par_wdata_o(par_wdata_o), .par_bias_gain_o(par_bias_gain_o),
		.par_second_sel_o(par_second_sel_o), .par_ack_i(par_ack_i), .par_rdata_i(par_rdata_i),
		.fault_clr_o(fault_clr_o), .par_clr_o(par_clr_o), .all_clr_o(all_clr_o),
		.comm_clr_o(comm_clr_o), .comm_keep_busy_o(comm_keep_busy_o), .clr_done_i(clr_done_i),
		.inv_reset_o(inv_reset_o), .mon_items_i(mon_items_i), .running_i(running_i),
		.set_freq_i(set_freq_i), .out_freq_i(out_freq_i),
		.panel_main_monitor_select_i(panel_main_monitor_select_i),
		.main_monitor_o(main_monitor_o));
	ich_core_model core (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .par_req_i(par_req_o),
		.par_we_i(par_we_o), .par_num_i(par_num_o), .par_wdata_i(par_wdata_o),
		.par_clr_i(par_clr_o), .all_clr_i(all_clr_o), .par_ack_o(par_ack_i),
		.par_rdata_o(par_rdata_i), .clr_done_o(clr_done_i));
	always @(posedge core_clk_i) begin
		cnt[0] += fault_clr_o;
		cnt[1] += inv_reset_o;
		cnt[2] += par_clr_o;
		cnt[3] += all_clr_o;
		cnt[4] += comm_clr_o;
		cnt[6] += comm_keep_busy_o;
		if (par_req_o === 1'b1) begin
			nreq++;
			l_num = par_num_o;
			l_wd = par_wdata_o;
			l_bg = par_bias_gain_o;
			l_we = par_we_o;
		end
	end
	task automatic conclude();
		if (failures == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
			failures++;
		end
	endtask
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		int i;
		@(posedge core_clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge core_clk_i);
			if (pready_o === 1'b1)
				break;
		end
		if (i == 50) begin
			failures++;
			conclude();
		end
		rd_v = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic exec(logic [7:0] c, logic [15:0] d);
		int i;
		apb(1, ich_pkg::OFS_DATA, {16'h0000, d});
		apb(1, ich_pkg::OFS_CODE, {24'h000000, c});
		for (i = 0; i < 100; i++) begin
			apb(0, ich_pkg::OFS_STATUS, 32'h0);
			if (rd_v[1:0] === 2'b00)
				break;
		end
		if (i == 100) begin
			failures++;
			conclude();
		end
		apb(0, ich_pkg::OFS_RESULT, 32'h0);
		res = rd_v;
	endtask
	initial begin
		foreach (cnt[i]) cnt[i] = 0;
		repeat (20) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		apb(0, ich_pkg::OFS_STATUS, 32'h0);
		chk("status sels at reset", 32'h0001_0000, rd_v & 32'h00ff_0303);
		apb(0, 8'h40, 32'h0);
		chk("unmapped slverr", 1, err);
		apb(0, 8'h06, 32'h0);
		chk("misaligned slverr", 1, err);
		apb(1, ich_pkg::OFS_EXT, 32'h3);
		exec(8'haa, 16'h0001); // ram write select set first
		chk("ram select number", 16'd342, l_num);
		apb(1, ich_pkg::OFS_EXT, 32'h0);
		exec(8'h85, 16'hfff0);
		chk("8888 written", ich_pkg::SP_8888, l_wd);
		chk("write request", 1, l_we);
		exec(8'h05, 16'h0);
		chk("8888 read", 32'h0000_fff0, res[16:0]);
		chk("read request", 0, l_we);
		exec(8'h86, 16'hffff);
		chk("9999 written", ich_pkg::SP_9999, l_wd);
		exec(8'h06, 16'h0);
		chk("9999 read", 32'h0000_ffff, res[16:0]);
		exec(8'he3, 16'h1234);
		chk("write number", 16'h0063, l_num);
		exec(8'h63, 16'h0);
		chk("read back", 32'h0000_1234, res[16:0]);
		exec(8'h08, 16'h0);
		chk("saturated read", 32'h0000_ffff, res[16:0]);
		for (int p = 0; p < 2; p++) begin
			snap[5] = nreq;
			exec(p ? 8'hcf : 8'hcd, 16'h0001);
			chk("protect error", 1, res[16]);
			chk("protect no request", snap[5], nreq);
		end
		exec(8'h6c, 16'h0);
		chk("second rd ext0", 1, res[16]);
		apb(1, ich_pkg::OFS_EXT, 32'h1);
		exec(8'hec, 16'h0002);
		chk("second sel out", 2'h2, par_second_sel_o);
		exec(8'h6c, 16'h0);
		chk("second sel read", 32'h0000_0002, res[16:0]);
		exec(8'hde, 16'h0010);
		chk("bias gain ext1", {1'b1, 16'd194}, {l_bg, l_num});
		apb(1, ich_pkg::OFS_EXT, 32'h9);
		exec(8'h91, 16'h0010);
		chk("bias gain ext9", {1'b1, 16'd917}, {l_bg, l_num});
		exec(8'hf3, 16'h1203);
		exec(8'h73, 16'h0);
		chk("special sel low byte", 32'h0000_0003, res[16:0]);
		exec(8'h72, 16'h0);
		chk("special monitor", 32'h0000_1003, res[16:0]);
		apb(1, ich_pkg::OFS_MSEL, 32'h0000_0100);
		apb(0, ich_pkg::OFS_MRES, 32'h0);
		chk("code 00 low", 16'h0000, rd_v[15:0]);
		apb(0, ich_pkg::OFS_MRES + 8'h04, 32'h0);
		chk("code 01 high", 16'h1001, rd_v[15:0]);
		apb(1, ich_pkg::OFS_MSEL, 32'h0000_0003);
		apb(0, ich_pkg::OFS_MRES + 8'h04, 32'h0);
		chk("code 00 high", 16'h1001, rd_v[15:0]);
		for (int w = 0; w < 4; w++) begin
			apb(1, ich_pkg::OFS_MSEL3 + 8'(4 * w), 32'(w + 4));
			apb(0, ich_pkg::OFS_MRES + 8'(8 + 4 * w), 32'h0);
			chk("monitor 3 to 6", (w == 3) ? 16'hffff : 16'(16'h1004 + w), rd_v[15:0]);
		end
		for (int i = 0; i < 9; i++) begin
			snap = cnt;
			exec(ccode[i], ckey[i]);
			seen = {cnt[6] != snap[6], res[16], cnt[4] != snap[4], cnt[3] != snap[3],
				cnt[2] != snap[2], cnt[1] != snap[1], cnt[0] != snap[0]};
			chk("key action", cexp[i], seen);
		end
		apb(0, ich_pkg::OFS_STATUS, 32'h0);
		chk("clear restores sels", 32'h0001_0000, rd_v & 32'h00ff_0300);
		apb(0, ich_pkg::OFS_MSEL, 32'h0);
		chk("clear restores msel", 16'h0000, rd_v[15:0]);
		for (int m = 0; m < 3; m++) begin
			@(posedge core_clk_i);
			panel_main_monitor_select_i <= (m == 2) ? 16'h0005 : ich_pkg::MAIN_SEL_AUTO;
			running_i <= (m == 1);
			repeat (3) @(posedge core_clk_i);
			chk("main monitor", (m == 0) ? set_freq_i : out_freq_i, main_monitor_o);
		end
		conclude();
	end
endmodule
